// >>> verilog/sic_dev.sv
// device end: configuration words, power-up load and serial access
`timescale 1ns/1ps
module sic_dev
    import sic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    sic_link_if.dev link,
    output logic [sic_pkg::IDX_W-1:0] nvmAddr,
    output logic nvmRead,
    input wire logic [sic_pkg::WORD_W-1:0] nvmData,
    output logic [2*sic_pkg::WORD_W-1:0] customerId,
    output logic [sic_pkg::SLAVE_ADDR_W-1:0] i2cAddr,
    output logic ssActiveHigh,
    output logic [sic_pkg::CLOCK_MODE_W-1:0] spiClockMode,
    output logic i2cSelected,
    output logic cfgReady
);
    import sic_pkg::*;

    // ****************************************************************
    // system domain: load from nonvolatile memory and apply writes
    // ****************************************************************
    sic_load_e loadState, next_loadState;
    logic [WORD_W-1:0] word [NUM_WORDS];
    logic [WORD_W-1:0] next_word [NUM_WORDS];
    logic [IDX_W-1:0] next_nvmAddr;
    logic next_nvmRead;
    logic selSync1, selSync2;
    logic tglSync1, tglSync2, tglSeen;
    logic wrToggle;
    logic [IDX_W-1:0] wrIdx;
    logic [WORD_W-1:0] wrData;
    logic [WORD_W-1:0] setup;

    assign setup = word[IDX_INTERFACE_SETUP];

    always_comb begin
        next_loadState = loadState;
        next_nvmAddr = nvmAddr;
        next_nvmRead = 1'b0;
        next_word = word;
        unique case (loadState)
            SIC_LD_REQ: begin
                next_nvmRead = 1'b1;
                next_loadState = SIC_LD_CAPTURE;
            end
            SIC_LD_CAPTURE: begin
                next_word[nvmAddr] = nvmData;
                if (nvmAddr == IDX_LAST) begin
                    next_loadState = SIC_LD_DONE;
                end else begin
                    next_nvmAddr = nvmAddr + 2'h1;
                    next_loadState = SIC_LD_REQ;
                end
            end
            SIC_LD_DONE: begin
                // unmapped index 3 is dropped; whole word kept
                if (tglSync2 != tglSeen && wrIdx <= IDX_LAST) begin
                    next_word[wrIdx] = wrData;
                end
            end
            default: next_loadState = SIC_LD_REQ;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            loadState <= SIC_LD_REQ;
            nvmAddr <= IDX_CUSTOMER_ID_LOW;
            nvmRead <= 1'b0;
            for (int i = 0; i < NUM_WORDS; i++) begin
                word[i] <= WORD_RESET;
            end
            selSync1 <= 1'b0;
            selSync2 <= 1'b0;
            tglSync1 <= 1'b0;
            tglSync2 <= 1'b0;
            tglSeen <= 1'b0;
        end else begin
            loadState <= next_loadState;
            nvmAddr <= next_nvmAddr;
            nvmRead <= next_nvmRead;
            word <= next_word;
            selSync1 <= link.sel;
            selSync2 <= selSync1;
            tglSync1 <= wrToggle;
            tglSync2 <= tglSync1;
            tglSeen <= tglSync2;
        end
    end

    // ****************************************************************
    // decoded settings, all registered
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            customerId <= {WORD_RESET, WORD_RESET};
            i2cAddr <= WORD_RESET[SLAVE_ADDR_W-1:0];
            ssActiveHigh <= 1'b0;
            spiClockMode <= WORD_RESET[CLOCK_MODE_W-1:0];
            i2cSelected <= 1'b0;
            cfgReady <= 1'b0;
        end else begin
            customerId <= {next_word[IDX_CUSTOMER_ID_HIGH],
                next_word[IDX_CUSTOMER_ID_LOW]};
            // programmer keeps 04..07 out; not policed here
            i2cAddr <= next_word[IDX_INTERFACE_SETUP]
                [SLAVE_ADDR_LSB +: SLAVE_ADDR_W];
            ssActiveHigh <=
                next_word[IDX_INTERFACE_SETUP][SS_POLARITY_BIT];
            spiClockMode <= next_word[IDX_INTERFACE_SETUP]
                [CLOCK_MODE_LSB +: CLOCK_MODE_W];
            i2cSelected <= selSync2;
            cfgReady <= (next_loadState == SIC_LD_DONE);
        end
    end

    // ****************************************************************
    // link domain: shift engine on the serial clock
    // ****************************************************************
    // settings words are held still while frames run, so the link logic
    // reads them as quasi-static values; host must not reprogram bit 9-11
    // in the middle of a frame
    logic ssActive, frameRstN, sampleClk;
    logic [BIT_CNT_W-1:0] bitCnt, next_bitCnt;
    logic [FRAME_BITS-2:0] rxShift, next_rxShift;
    logic [WORD_W-1:0] outShift, next_outShift;
    logic next_wrToggle;
    logic [IDX_W-1:0] next_wrIdx;
    logic [WORD_W-1:0] next_wrData;
    logic [CMD_W-1:0] lastCmd;
    logic [WORD_W-1:0] readWord;

    assign ssActive = (link.ss == setup[SS_POLARITY_BIT]);
    // the frame ends by its own select going idle, no trailing edge needed
    assign frameRstN = nrst & ssActive & cfgReady & ~selSync2;
    // sampling edge rising for modes 00 and 11, falling for 01 and 10
    assign sampleClk = link.sclk ^
        (setup[CLOCK_POLARITY_BIT] ^ setup[CLOCK_PHASE_BIT]);
    assign lastCmd = rxShift[FRAME_BITS-2 -: CMD_W];

    always_comb begin
        next_rxShift = {rxShift[FRAME_BITS-3:0], link.mosi};
        next_bitCnt = (bitCnt == FRAME_COUNT) ? bitCnt : bitCnt + 5'h01;
        next_wrToggle = wrToggle;
        next_wrIdx = wrIdx;
        next_wrData = wrData;
        if (bitCnt == LAST_BIT_COUNT && lastCmd[CMD_WRITE_BIT]) begin
            next_wrToggle = ~wrToggle;
            next_wrIdx = lastCmd[IDX_W-1:0];
            next_wrData = next_rxShift[WORD_W-1:0];
        end
    end

    always_ff @(posedge sampleClk or negedge frameRstN) begin
        if (!frameRstN) begin
            bitCnt <= '0;
            rxShift <= '0;
        end else begin
            bitCnt <= next_bitCnt;
            rxShift <= next_rxShift;
        end
    end

    // write request outlives the frame, so only system reset clears it
    always_ff @(posedge sampleClk or negedge nrst) begin
        if (!nrst) begin
            wrToggle <= 1'b0;
            wrIdx <= IDX_CUSTOMER_ID_LOW;
            wrData <= WORD_RESET;
        end else begin
            wrToggle <= next_wrToggle;
            wrIdx <= next_wrIdx;
            wrData <= next_wrData;
        end
    end

    always_comb begin
        readWord = WORD_UNMAPPED;
        if (rxShift[IDX_W-1:0] <= IDX_LAST) begin
            readWord = word[rxShift[IDX_W-1:0]];
        end
        next_outShift = {outShift[WORD_W-2:0], 1'b0};
        if (bitCnt == CMD_DONE_COUNT) begin
            next_outShift = readWord;
        end
    end

    // output changes on the edge opposite the sampling edge
    always_ff @(negedge sampleClk or negedge frameRstN) begin
        if (!frameRstN) begin
            outShift <= WORD_RESET;
        end else begin
            outShift <= next_outShift;
        end
    end

    assign link.misoOut = outShift[WORD_W-1];
    assign link.misoOe = frameRstN;

endmodule // sic_dev

// >>> verilog/sic_pkg.sv
// shared constants and types for the serial interface configuration block
package sic_pkg;

    // ****************************************************************
    // word map and field layout
    // ****************************************************************
    localparam int WORD_W = 16;
    localparam int IDX_W = 2;
    localparam int NUM_WORDS = 3;
    localparam logic [IDX_W-1:0] IDX_CUSTOMER_ID_LOW = 2'h0;
    localparam logic [IDX_W-1:0] IDX_CUSTOMER_ID_HIGH = 2'h1;
    localparam logic [IDX_W-1:0] IDX_INTERFACE_SETUP = 2'h2;
    localparam logic [IDX_W-1:0] IDX_LAST = 2'h2;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_UNMAPPED = 16'h0000;

    localparam int SLAVE_ADDR_LSB = 0;
    localparam int SLAVE_ADDR_W = 7;
    localparam int SS_POLARITY_BIT = 9;
    localparam int CLOCK_PHASE_BIT = 10;
    localparam int CLOCK_POLARITY_BIT = 11;
    localparam int CLOCK_MODE_LSB = 10;
    localparam int CLOCK_MODE_W = 2;

    // ****************************************************************
    // link frame: command byte then one data word
    // ****************************************************************
    localparam int CMD_W = 8;
    localparam int FRAME_BITS = 24;
    localparam int BIT_CNT_W = 5;
    localparam int CMD_WRITE_BIT = 7;
    localparam logic [BIT_CNT_W-1:0] CMD_DONE_COUNT = 5'h08;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT_COUNT = 5'h17;
    localparam logic [BIT_CNT_W-1:0] FRAME_COUNT = 5'h18;
    localparam logic [4:0] CMD_PAD = 5'h00;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SYS_CLK_NS = 100;
    localparam int SCLK_HALF_NS = 400;
    localparam int SCLK_HALF_CYC =
        (SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int HALF_CNT_W = 3;
    localparam int EDGE_CNT_W = 6;
    localparam logic [EDGE_CNT_W-1:0] FRAME_EDGES = 6'h30;

    // ****************************************************************
    // state machines
    // ****************************************************************
    typedef enum logic [1:0] {
        SIC_LD_REQ = 2'b00,
        SIC_LD_CAPTURE = 2'b01,
        SIC_LD_DONE = 2'b10
    } sic_load_e;

    typedef enum logic [2:0] {
        SIC_H_IDLE = 3'b000,
        SIC_H_SETUP = 3'b001,
        SIC_H_CLOCK = 3'b010,
        SIC_H_HOLD = 3'b011,
        SIC_H_GAP = 3'b100
    } sic_host_e;

endpackage

// >>> verilog/sic_link_if.sv
// serial link between the configured device and the host controller
`timescale 1ns/1ps
interface sic_link_if;
    logic sclk;
    logic ss;
    logic mosi;
    logic misoOut;
    logic misoOe;
    logic sel;
    logic misoLine;

    // pulled low when the device releases the line
    assign misoLine = misoOe ? misoOut : 1'b0;

    modport dev (
        input sclk,
        input ss,
        input mosi,
        input sel,
        output misoOut,
        output misoOe
    );

    modport host (
        output sclk,
        output ss,
        output mosi,
        output sel,
        input misoLine
    );
endinterface

// >>> verilog/sic_host.sv
// host end: spi master that reads and writes the configuration words
`timescale 1ns/1ps
module sic_host
    import sic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    sic_link_if.host link,
    input wire logic useI2c,
    input wire logic ssActiveHigh,
    input wire logic [sic_pkg::CLOCK_MODE_W-1:0] spiClockMode,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [sic_pkg::IDX_W-1:0] reqIdx,
    input wire logic [sic_pkg::WORD_W-1:0] reqData,
    output logic reqReady,
    output logic rspValid,
    output logic [sic_pkg::WORD_W-1:0] rspData
);
    import sic_pkg::*;

    // ****************************************************************
    // frame sequencer
    // ****************************************************************
    sic_host_e state, next_state;
    logic [HALF_CNT_W-1:0] halfCnt, next_halfCnt;
    logic [EDGE_CNT_W-1:0] edgeCnt, next_edgeCnt;
    logic [FRAME_BITS-1:0] txShift, next_txShift;
    logic [WORD_W-1:0] next_rspData;
    logic sclk, next_sclk, ss, next_ss, mosi, next_mosi, sel;
    logic next_reqReady, next_rspValid;
    logic misoSync1, misoSync2;
    logic cpol, cpha, halfDone, leading;

    assign cpol = spiClockMode[CLOCK_POLARITY_BIT - CLOCK_MODE_LSB];
    assign cpha = spiClockMode[CLOCK_PHASE_BIT - CLOCK_MODE_LSB];
    assign halfDone = (halfCnt == HALF_CNT_W'(SCLK_HALF_CYC - 1));
    assign leading = ~edgeCnt[0];

    always_comb begin
        next_state = state;
        next_halfCnt = halfDone ? '0 : halfCnt + 3'h1;
        next_edgeCnt = edgeCnt;
        next_txShift = txShift;
        next_rspData = rspData;
        next_sclk = sclk;
        next_ss = ss;
        next_mosi = mosi;
        next_reqReady = 1'b0;
        next_rspValid = 1'b0;
        unique case (state)
            SIC_H_IDLE: begin
                next_halfCnt = '0;
                next_sclk = cpol;
                next_ss = ~ssActiveHigh;
                next_reqReady = ~useI2c;
                if (reqValid && reqReady) begin
                    next_reqReady = 1'b0;
                    next_ss = ssActiveHigh;
                    next_edgeCnt = '0;
                    next_txShift = {reqWrite, CMD_PAD, reqIdx, reqData};
                    if (!cpha) begin
                        next_mosi = reqWrite;
                        next_txShift = {CMD_PAD, reqIdx, reqData, 1'b0};
                    end
                    next_state = SIC_H_SETUP;
                end
            end
            SIC_H_SETUP: begin
                if (halfDone) begin
                    next_state = SIC_H_CLOCK;
                end
            end
            SIC_H_CLOCK: begin
                if (halfDone) begin
                    next_sclk = ~sclk;
                    next_edgeCnt = edgeCnt + 6'h01;
                    // phase 0 drives on trailing edges, phase 1 on leading
                    if (leading == cpha) begin
                        next_mosi = txShift[FRAME_BITS-1];
                        next_txShift = {txShift[FRAME_BITS-2:0], 1'b0};
                    end else begin
                        next_rspData = {rspData[WORD_W-2:0], misoSync2};
                    end
                    if (next_edgeCnt == FRAME_EDGES) begin
                        next_state = SIC_H_HOLD;
                    end
                end
            end
            SIC_H_HOLD: begin
                if (halfDone) begin
                    next_ss = ~ssActiveHigh;
                    next_state = SIC_H_GAP;
                end
            end
            SIC_H_GAP: begin
                if (halfDone) begin
                    next_rspValid = 1'b1;
                    next_reqReady = ~useI2c;
                    next_state = SIC_H_IDLE;
                end
            end
            default: next_state = SIC_H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= SIC_H_IDLE;
            halfCnt <= '0;
            edgeCnt <= '0;
            txShift <= '0;
            rspData <= WORD_RESET;
            sclk <= 1'b0;
            ss <= 1'b1;
            mosi <= 1'b0;
            sel <= 1'b0;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            misoSync1 <= 1'b0;
            misoSync2 <= 1'b0;
        end else begin
            state <= next_state;
            halfCnt <= next_halfCnt;
            edgeCnt <= next_edgeCnt;
            txShift <= next_txShift;
            rspData <= next_rspData;
            sclk <= next_sclk;
            ss <= next_ss;
            mosi <= next_mosi;
            sel <= useI2c;
            reqReady <= next_reqReady;
            rspValid <= next_rspValid;
            misoSync1 <= link.misoLine;
            misoSync2 <= misoSync1;
        end
    end

    assign link.sclk = sclk;
    assign link.ss = ss;
    assign link.mosi = mosi;
    assign link.sel = sel;

endmodule // sic_host

// >>> tb/sic_link_asserts.sv
// wire-level assertions for the serial configuration link
`timescale 1ns/1ps
module sic_link_asserts
    import sic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic ss,
    input wire logic mosi,
    input wire logic misoOut,
    input wire logic misoOe,
    input wire logic sel,
    input wire logic ssActiveHigh,
    input wire logic [sic_pkg::CLOCK_MODE_W-1:0] spiClockMode
);
    import sic_pkg::*;

    // ****************************************************************
    // helper state
    // ****************************************************************
    logic [1:0] settleCnt, next_settleCnt;
    logic prevSclk, next_prevSclk;
    logic [EDGE_CNT_W-1:0] edgeCnt, next_edgeCnt;
    logic settled, ssAct, outLevel;

    // host idle levels are only trusted from the third edge after reset
    assign settled = (settleCnt == 2'h2);
    assign ssAct = settled && (ss == ssActiveHigh);
    // sclk level after the edge on which data is launched
    assign outLevel = spiClockMode[1] ^ spiClockMode[0];

    always_comb begin
        next_settleCnt = settled ? settleCnt : settleCnt + 2'h1;
        next_prevSclk = sclk;
        next_edgeCnt = ssAct ? edgeCnt + {5'h00, sclk != prevSclk} : 6'h00;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            settleCnt <= 2'h0;
            prevSclk <= 1'b0;
            edgeCnt <= 6'h00;
        end else begin
            settleCnt <= next_settleCnt;
            prevSclk <= next_prevSclk;
            edgeCnt <= next_edgeCnt;
        end
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    ss_level_a: assert property (
        misoOe |-> ss == ssActiveHigh)
        else $error("miso driven while slave select inactive");
    sel_blocks_a: assert property (
        sel && $past(sel, 4) |-> !misoOe)
        else $error("miso driven in i2c operation");
    idle_level_a: assert property (
        settled && !ssAct |-> sclk == spiClockMode[1])
        else $error("sclk not at idle level outside frame");
    launch_edge_a: assert property (
        misoOe && $past(misoOe) && $changed(misoOut)
        |-> $changed(sclk) && sclk == outLevel)
        else $error("miso changed off the launch edge");
    mosi_launch_a: assert property (
        ssAct && $past(ssAct) && $changed(mosi) |-> sclk == outLevel)
        else $error("mosi changed off the launch edge");
    frame_edges_a: assert property (
        $fell(ssAct) |-> edgeCnt == FRAME_EDGES)
        else $error("frame edge count wrong");
    frame_gap_a: assert property (
        $fell(ssAct) |-> !ssAct [*4])
        else $error("slave select gap too short");
    half_period_a: assert property (
        settled && $changed(sclk) |=> $stable(sclk) [*3])
        else $error("sclk half period too short");
endmodule // sic_link_asserts

// >>> tb/tb_top.sv
// self-checking bench: device and host ends joined over the link
`timescale 1ns/1ps
module tb_top;
    import sic_pkg::*;
    logic sys_clk, nrst, useI2c, ssActiveHigh, reqValid, reqWrite;
    logic reqReady, rspValid, nvmRead, devSsHigh, i2cSelected, cfgReady;
    logic [CLOCK_MODE_W-1:0] spiClockMode, devMode;
    logic [IDX_W-1:0] reqIdx, nvmAddr;
    logic [WORD_W-1:0] reqData, rspData, nvmData;
    logic [WORD_W-1:0] nvmMem [0:3];
    logic [2*WORD_W-1:0] customerId;
    logic [SLAVE_ADDR_W-1:0] i2cAddr;
    int model [0:3];
    int num_errors, samples_checked, seed, k, i, n, reads;
    logic [31:0] expv;

    sic_link_if link ();
    assign nvmData = nvmMem[nvmAddr];
    sic_dev sic_dev_i (.sys_clk(sys_clk), .nrst(nrst), .link(link),
        .nvmAddr(nvmAddr), .nvmRead(nvmRead), .nvmData(nvmData),
        .customerId(customerId), .i2cAddr(i2cAddr), .ssActiveHigh(devSsHigh),
        .spiClockMode(devMode), .i2cSelected(i2cSelected),
        .cfgReady(cfgReady));
    sic_host sic_host_i (.sys_clk(sys_clk), .nrst(nrst), .link(link),
        .useI2c(useI2c), .ssActiveHigh(ssActiveHigh),
        .spiClockMode(spiClockMode), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqIdx(reqIdx), .reqData(reqData),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
    sic_link_asserts sic_link_asserts_i (.sys_clk(sys_clk), .nrst(nrst),
        .sclk(link.sclk), .ss(link.ss), .mosi(link.mosi),
        .misoOut(link.misoOut), .misoOe(link.misoOe), .sel(link.sel),
        .ssActiveHigh(ssActiveHigh), .spiClockMode(spiClockMode));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp,
        input logic got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // setup word with chosen mode bits; addresses 04-07 are never used
    function automatic logic [WORD_W-1:0] pick_setup(input logic [2:0] ctl);
        logic [WORD_W-1:0] v;
        v = 16'($random(seed));
        v[11:9] = ctl;
        if (v[6:2] == 5'h01) v[6] = 1'b1;
        return v;
    endfunction

    task automatic do_reset();
        step(8);
        chk_word("customerId", 32'h0, customerId);
        nrst = 1'b1;
        // load takes three read pulses two cycles apart
        reads = 0;
        for (n = 0; n < 6; n++) begin
            step(1);
            reads += int'(nvmRead);
        end
        chk_word("nvmRead", NUM_WORDS, reads);
        chk_flag("cfgReady", 1'b1, cfgReady);
        expv = {nvmMem[1], nvmMem[0]};
        chk_word("customerId", expv, customerId);
        expv = {25'h0, nvmMem[2][6:0]};
        chk_word("i2cAddr", expv, 32'(i2cAddr));
        chk_flag("ssActiveHigh", nvmMem[2][9], devSsHigh);
        expv = {30'h0, nvmMem[2][11:10]};
        chk_word("spiClockMode", expv, 32'(devMode));
        chk_flag("i2cSelected", 1'b0, i2cSelected);
        step(2);
    endtask

    task automatic xfer(input logic w, input logic [IDX_W-1:0] idx,
        input logic [WORD_W-1:0] d);
        for (n = 0; n < 20 && reqReady !== 1'b1; n++) step(1);
        if (reqReady !== 1'b1) begin
            num_errors++;
            test_done();
        end
        reqValid = 1'b1;
        reqWrite = w;
        reqIdx = idx;
        reqData = d;
        step(1);
        reqValid = 1'b0;
        for (n = 0; n < 260 && rspValid !== 1'b1; n++) step(1);
        if (rspValid !== 1'b1) begin
            num_errors++;
            test_done();
        end
        chk_word("rspData", model[idx], 32'(rspData));
        if (w && idx != 2'h3) model[idx] = d;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        num_errors = 0;
        samples_checked = 0;
        seed = 75654;
        nrst = 1'b0;
        useI2c = 1'b0;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqIdx = 2'h0;
        reqData = 16'h0000;
        for (i = 0; i < 4; i++) nvmMem[i] = 16'h0000;
        for (k = 0; k < 4; k++) begin
            nrst = 1'b0;
            if (k > 0) begin
                nvmMem[0] = 16'($random(seed));
                nvmMem[1] = 16'($random(seed));
                nvmMem[2] = pick_setup({k[1:0], ~k[0]});
            end
            for (i = 0; i < 4; i++) model[i] = int'(nvmMem[i]);
            ssActiveHigh = nvmMem[2][9];
            spiClockMode = nvmMem[2][11:10];
            do_reset();
            for (i = 0; i < 4; i++) xfer(1'b0, i[1:0], 16'($random(seed)));
            for (i = 0; i < 4; i++) begin
                xfer(1'b1, i[1:0], (i == 2) ? pick_setup(nvmMem[2][11:9])
                    : 16'($random(seed)));
            end
            for (i = 3; i >= 0; i--) xfer(1'b0, i[1:0], 16'($random(seed)));
            expv = {model[1][15:0], model[0][15:0]};
            chk_word("customerId", expv, customerId);
            expv = model[2] & 32'h7f;
            chk_word("i2cAddr", expv, 32'(i2cAddr));
            chk_flag("ssActiveHigh", model[2][9], devSsHigh);
        end
        useI2c = 1'b1;
        step(6);
        chk_flag("i2cSelected", 1'b1, i2cSelected);
        chk_flag("reqReady", 1'b0, reqReady);
        reqValid = 1'b1;
        step(20);
        chk_flag("ss", ~ssActiveHigh, link.ss);
        reqValid = 1'b0;
        useI2c = 1'b0;
        step(4);
        xfer(1'b0, 2'h2, 16'h0000);
        test_done();
    end
endmodule // tb_top
